//--- rtl/msf_pkg.sv
// Constants, field layouts and carrier types of the serial command framer
//
// How it works
// - Reset leaves the framer in the receive state.
// - An accepted send command moves the framer to the transmit state.
// - One send command yields one packet of at most 255 message bytes.
// - Addressed packets are acknowledged; sender reports the outcome.
// - A failed packet-mode send is dropped, not kept.
// - A finished transmission returns the framer to receive.
// - Four send commands; received data gets the matching header.
// - Text send: @, command, address, message, CRLF; received with header.
// - Binary send adds a three-digit byte count setting the length.
// - Received binary: header, sender, count, message, CRLF.
// - Relay variants are inactive and refused.
// - Destination 255 is broadcast: no acknowledgement either way.
// - A broadcast uses every retry and then reports an end response.
// - A broadcast is output once; retransmitted copies are suppressed.
// - Stream mode treats every host byte as payload.
// - Stream destination comes from stored configuration.
// - Stream trigger: terminator byte, idle timeout or byte count.
// - A stream packet holds at most 255 bytes, terminator included.
// - Stream mode emits no success or failure response to the host.
// - Stream data is buffered; the host keeps sending meanwhile.
// - Stream output has no header or added CRLF; terminators pass.
// - Stream text received in packet mode gets header, payload, own CRLF.
// - Stream binary received in packet mode counts the terminator.
// - Terminator trigger fires on the terminator or on 255 accumulated bytes.
// - Timeout trigger fires after the configured idle time or on 255 bytes.
package msf_pkg;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;

  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMEOUT_UNIT_NS = 1_000_000;
  localparam int TICKS_PER_MS_DEF = TIMEOUT_UNIT_NS / CLK_PERIOD_NS;

  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] BCAST_ADDR = 8'hff;
  localparam logic [7:0] MAX_MSG = 8'hff;
  localparam logic [9:0] MAX_FIELD = 10'h0ff;

  // Three-letter commands and headers, first letter in the top byte
  localparam logic [23:0] CMD_TEXT = 24'h545854;
  localparam logic [23:0] CMD_TEXT_RELAY = 24'h545852;
  localparam logic [23:0] CMD_BIN = 24'h54424e;
  localparam logic [23:0] CMD_BIN_RELAY = 24'h544252;
  localparam logic [23:0] HDR_TEXT = 24'h525854;
  localparam logic [23:0] HDR_BIN = 24'h52424e;

  // Two-letter responses
  localparam logic [15:0] RESP_SEND_OK = 16'h5030;
  localparam logic [15:0] RESP_CMD_ACCEPTED = 16'h5031;
  localparam logic [15:0] RESP_CMD_ERROR = 16'h4e31;
  localparam logic [15:0] RESP_SEND_FAIL = 16'h4e32;

  localparam logic [1:0] TRIG_TERM = 2'h0;
  localparam logic [1:0] TRIG_TIMEOUT = 2'h1;
  localparam logic [1:0] TRIG_COUNT = 2'h2;

  typedef struct packed {
    logic [7:0] dest;
    logic [7:0] len;
    logic binary;
    logic bcast;
    logic drop;
  } msf_tx_desc_type;

  typedef struct packed {
    logic [7:0] src;
    logic [7:0] len;
    logic binary;
    logic bcast;
    logic seq;
  } msf_rx_head_type;

  // ASCII digit of an 8-bit value; pos 0 is hundreds
  function automatic logic [7:0] msf_digit(input logic [7:0] v, input logic [1:0] pos);
    logic [7:0] d;
    d = 8'h00;
    case (pos)
      2'h0: d = v / 8'd100;
      2'h1: d = (v / 8'd10) % 8'd10;
      default: d = v % 8'd10;
    endcase
    return d + CH_0;
  endfunction

endpackage

//--- rtl/msf_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill level
module msf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // Occupancy
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  assign level = wr_ptr_r - rd_ptr_r;
  assign in_ready = level != (AW + 1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

//--- rtl/msf_framer.sv
// Host command interpreter and output framer of the packet modem
module msf_framer
  import msf_pkg::*;
#(
  parameter int unsigned TICKS_PER_MS = TICKS_PER_MS_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stored configuration
  input wire logic cfg_stream_mode,
  input wire logic [1:0] cfg_trigger,
  input wire logic [7:0] cfg_term,
  input wire logic [7:0] cfg_count,
  input wire logic [7:0] cfg_timeout_ms,
  input wire logic [7:0] cfg_dest,
  // Host byte input
  input wire logic hin_valid,
  input wire logic [7:0] hin_data,
  output logic hin_ready,
  // Host byte output
  output logic hout_valid,
  output logic [7:0] hout_data,
  input wire logic hout_ready,
  // Radio transmit side
  output logic radio_byte_valid,
  output logic [7:0] radio_byte,
  input wire logic radio_byte_ready,
  output logic radio_req_valid,
  output msf_tx_desc_type radio_req,
  input wire logic radio_req_ready,
  input wire logic radio_done,
  input wire logic radio_ok,
  // Radio receive side
  input wire logic rx_head_valid,
  input wire msf_rx_head_type rx_head,
  output logic rx_head_ready,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_byte_ready,
  output logic ack_req,
  // Status
  output logic in_tx
);

  typedef enum logic [2:0] {
    P_IDLE = 3'h0, P_CMD = 3'h1, P_ADDR = 3'h3, P_CNT = 3'h2,
    P_MSG = 3'h6, P_CR = 3'h7, P_LF = 3'h5, P_ERR = 3'h4
  } msf_pstate_type;

  typedef enum logic [2:0] {
    O_IDLE = 3'h0, O_RSP = 3'h1, O_HDR = 3'h3, O_DATA = 3'h2, O_CR = 3'h6, O_LF = 3'h7
  } msf_ostate_type;

  // Host input side
  msf_pstate_type pst_r;
  logic hin_ready_r;
  logic [15:0] cmd_r;
  logic [1:0] dcnt_r;
  logic [9:0] acc_r;
  logic [9:0] acc_nxt;
  logic bin_r;
  logic [7:0] dest_r;
  logic [7:0] cnt_r;
  logic [7:0] msg_cnt_r;
  logic [7:0] seg_len_r;
  logic [23:0] idle_r;
  logic [23:0] tmo_lim;
  logic desc_valid_r;
  msf_tx_desc_type desc_r;
  logic wait_done_r;
  logic ok_evt_r;
  logic err_evt_r;
  logic in_tx_r;
  logic take;
  logic is_dig;
  logic [23:0] cmd3;
  logic pk_fail;
  logic st_fire;
  logic tmo_fire;
  logic push;

  // Buffer toward the radio
  logic fifo_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_out_ready;
  logic [LEVEL_W-1:0] fifo_level;
  logic radio_byte_valid_r;
  logic [7:0] radio_byte_r;

  // Responses and output framing
  logic acc_pend_r;
  logic [15:0] acc_code_r;
  logic fin_pend_r;
  logic [15:0] fin_code_r;
  msf_ostate_type ost_r;
  msf_ostate_type ost_nxt;
  logic [3:0] oidx_r;
  logic [3:0] oidx_nxt;
  logic [7:0] left_r;
  logic [7:0] left_nxt;
  logic drop_r;
  logic drop_nxt;
  logic ostream_r;
  logic ostream_nxt;
  logic [15:0] rsp_code_r;
  msf_rx_head_type hd_r;
  logic hout_valid_r;
  logic hout_valid_nxt;
  logic [7:0] hout_data_r;
  logic rx_head_ready_r;
  logic rx_byte_ready_r;
  logic ack_req_r;
  logic seen_r;
  logic [7:0] last_src_r;
  logic last_seq_r;
  logic free;
  logic emit;
  logic [7:0] ebyte;
  logic head_take;
  logic byte_take;
  logic take_acc;
  logic take_fin;
  logic dup;
  logic [23:0] hdr;

  assign take = hin_valid && hin_ready_r;
  assign is_dig = hin_data >= CH_0 && hin_data <= CH_9;
  assign acc_nxt = 10'(acc_r * 10'd10) + 10'(hin_data - CH_0);
  assign cmd3 = {cmd_r, hin_data};
  assign tmo_lim = 24'(cfg_timeout_ms) * 24'(TICKS_PER_MS);

  // Malformed command detection for the byte being taken
  always_comb begin
    pk_fail = 1'b0;
    case (pst_r)
      P_CMD: pk_fail = dcnt_r == 2'h2 && cmd3 != CMD_TEXT && cmd3 != CMD_BIN;
      P_ADDR, P_CNT: pk_fail = !is_dig || (dcnt_r == 2'h2 && acc_nxt > MAX_FIELD);
      P_MSG: pk_fail = !bin_r && hin_data != CH_CR && msg_cnt_r == MAX_MSG;
      P_CR: pk_fail = hin_data != CH_CR;
      P_LF: pk_fail = hin_data != CH_LF;
      default: pk_fail = 1'b0;
    endcase
  end

  // Stream triggers
  assign st_fire = (cfg_trigger == TRIG_TERM && hin_data == cfg_term)
    || (cfg_trigger == TRIG_COUNT && 8'(seg_len_r + 8'h01) == cfg_count)
    || seg_len_r == MAX_MSG - 8'h01;
  assign tmo_fire = cfg_stream_mode && cfg_trigger == TRIG_TIMEOUT && seg_len_r != 8'h00
    && !desc_valid_r && idle_r >= tmo_lim;

  assign push = take && (cfg_stream_mode
    || (pst_r == P_MSG && !pk_fail && (bin_r || hin_data != CH_CR)));

  // Host input: command parsing, stream segmentation and send requests
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pst_r <= P_IDLE;
      cmd_r <= 16'h0000;
      dcnt_r <= 2'h0;
      acc_r <= 10'h000;
      bin_r <= 1'b0;
      dest_r <= 8'h00;
      cnt_r <= 8'h00;
      msg_cnt_r <= 8'h00;
      seg_len_r <= 8'h00;
      idle_r <= 24'h000000;
      desc_valid_r <= 1'b0;
      desc_r <= '0;
      wait_done_r <= 1'b0;
      ok_evt_r <= 1'b0;
      err_evt_r <= 1'b0;
    end else begin
      ok_evt_r <= 1'b0;
      err_evt_r <= 1'b0;
      if (desc_valid_r && radio_req_ready) begin
        desc_valid_r <= 1'b0;
      end
      if (radio_done) begin
        wait_done_r <= 1'b0;
      end
      if (cfg_stream_mode) begin
        if (take) begin
          idle_r <= 24'h000000;
          if (st_fire) begin
            desc_valid_r <= 1'b1;
            desc_r <= '{dest: cfg_dest, len: 8'(seg_len_r + 8'h01), binary: 1'b0,
                        bcast: cfg_dest == BCAST_ADDR, drop: 1'b0};
            seg_len_r <= 8'h00;
          end else begin
            seg_len_r <= seg_len_r + 8'h01;
          end
        end else if (tmo_fire) begin
          desc_valid_r <= 1'b1;
          desc_r <= '{dest: cfg_dest, len: seg_len_r, binary: 1'b0,
                      bcast: cfg_dest == BCAST_ADDR, drop: 1'b0};
          seg_len_r <= 8'h00;
          idle_r <= 24'h000000;
        end else if (seg_len_r != 8'h00 && idle_r < tmo_lim) begin
          idle_r <= idle_r + 24'h000001;
        end
      end else if (take) begin
        if (pk_fail || (pst_r == P_ERR && hin_data == CH_LF)) begin
          if (hin_data == CH_LF) begin
            pst_r <= P_IDLE;
            err_evt_r <= 1'b1;
            // Bytes already handed on are cancelled, not sent
            if (msg_cnt_r != 8'h00) begin
              desc_valid_r <= 1'b1;
              desc_r <= '{dest: dest_r, len: msg_cnt_r, binary: bin_r,
                          bcast: 1'b0, drop: 1'b1};
            end
          end else begin
            pst_r <= P_ERR;
          end
        end else begin
          case (pst_r)
            P_IDLE: begin
              if (hin_data == CH_AT) begin
                pst_r <= P_CMD;
                dcnt_r <= 2'h0;
                msg_cnt_r <= 8'h00;
              end
            end
            P_CMD: begin
              cmd_r <= cmd3[15:0];
              dcnt_r <= dcnt_r + 2'h1;
              if (dcnt_r == 2'h2) begin
                bin_r <= cmd3 == CMD_BIN;
                dcnt_r <= 2'h0;
                acc_r <= 10'h000;
                pst_r <= P_ADDR;
              end
            end
            P_ADDR, P_CNT: begin
              acc_r <= acc_nxt;
              dcnt_r <= dcnt_r + 2'h1;
              if (dcnt_r == 2'h2) begin
                dcnt_r <= 2'h0;
                acc_r <= 10'h000;
                if (pst_r == P_ADDR) begin
                  dest_r <= acc_nxt[7:0];
                  pst_r <= bin_r ? P_CNT : P_MSG;
                end else begin
                  cnt_r <= acc_nxt[7:0];
                  pst_r <= acc_nxt[7:0] == 8'h00 ? P_CR : P_MSG;
                end
              end
            end
            P_MSG: begin
              if (!bin_r && hin_data == CH_CR) begin
                pst_r <= P_LF;
              end else begin
                msg_cnt_r <= msg_cnt_r + 8'h01;
                if (bin_r && 8'(msg_cnt_r + 8'h01) == cnt_r) begin
                  pst_r <= P_CR;
                end
              end
            end
            P_CR: pst_r <= P_LF;
            P_LF: begin
              pst_r <= P_IDLE;
              ok_evt_r <= 1'b1;
              desc_valid_r <= 1'b1;
              desc_r <= '{dest: dest_r, len: msg_cnt_r, binary: bin_r,
                          bcast: dest_r == BCAST_ADDR, drop: 1'b0};
              wait_done_r <= 1'b1;
            end
            default: pst_r <= pst_r;
          endcase
        end
      end
    end
  end

  // Ready drops for a cycle after each byte so a fresh request is seen first;
  // the serial line is far slower than this clock, so no rate is lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hin_ready_r <= 1'b0;
      in_tx_r <= 1'b0;
    end else begin
      hin_ready_r <= !take && !tmo_fire && !desc_valid_r && !wait_done_r
        && fifo_level <= LEVEL_W'(FIFO_DEPTH - 2);
      in_tx_r <= desc_valid_r || wait_done_r;
    end
  end

  msf_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_data(hin_data),
    .in_ready(fifo_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready),
    .level(fifo_level)
  );

  assign fifo_out_ready = !radio_byte_valid_r || radio_byte_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      radio_byte_valid_r <= 1'b0;
      radio_byte_r <= 8'h00;
    end else if (fifo_out_ready) begin
      radio_byte_valid_r <= fifo_out_valid;
      if (fifo_out_valid) begin
        radio_byte_r <= fifo_out_data;
      end
    end
  end

  // Pending responses; a new event wins over the clear by the output side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_pend_r <= 1'b0;
      acc_code_r <= RESP_CMD_ACCEPTED;
      fin_pend_r <= 1'b0;
      fin_code_r <= RESP_SEND_OK;
    end else begin
      if (ok_evt_r || err_evt_r) begin
        acc_pend_r <= 1'b1;
        acc_code_r <= ok_evt_r ? RESP_CMD_ACCEPTED : RESP_CMD_ERROR;
      end else if (take_acc) begin
        acc_pend_r <= 1'b0;
      end
      if (radio_done && wait_done_r) begin
        fin_pend_r <= 1'b1;
        // Broadcast always ends with the end response after all retries
        fin_code_r <= (desc_r.bcast || radio_ok) ? RESP_SEND_OK : RESP_SEND_FAIL;
      end else if (take_fin) begin
        fin_pend_r <= 1'b0;
      end
    end
  end

  assign free = !hout_valid_r || hout_ready;
  assign byte_take = rx_byte_valid && rx_byte_ready_r;
  assign dup = rx_head.bcast && seen_r && last_src_r == rx_head.src
    && last_seq_r == rx_head.seq;
  assign hdr = hd_r.binary ? HDR_BIN : HDR_TEXT;

  // Output framing: a received header goes before pending responses; then header, data and line ends, data alone in stream mode, nothing for a duplicate
  always_comb begin
    ost_nxt = ost_r;
    oidx_nxt = oidx_r;
    left_nxt = left_r;
    drop_nxt = drop_r;
    ostream_nxt = ostream_r;
    emit = 1'b0;
    ebyte = 8'h00;
    head_take = 1'b0;
    take_acc = 1'b0;
    take_fin = 1'b0;
    case (ost_r)
      O_IDLE: begin
        oidx_nxt = 4'h0;
        if (rx_head_valid && rx_head_ready_r) begin
          head_take = 1'b1;
          left_nxt = rx_head.len;
          drop_nxt = dup;
          ostream_nxt = cfg_stream_mode;
          if (dup || cfg_stream_mode) begin
            ost_nxt = rx_head.len == 8'h00 ? O_IDLE : O_DATA;
          end else begin
            ost_nxt = O_HDR;
          end
        end else if (acc_pend_r) begin
          take_acc = 1'b1;
          ost_nxt = O_RSP;
        end else if (fin_pend_r) begin
          take_fin = 1'b1;
          ost_nxt = O_RSP;
        end
      end
      O_RSP: begin
        if (free) begin
          emit = 1'b1;
          ebyte = oidx_r == 4'h0 ? rsp_code_r[15:8] : rsp_code_r[7:0];
          oidx_nxt = oidx_r + 4'h1;
          if (oidx_r == 4'h1) begin
            ost_nxt = O_CR;
          end
        end
      end
      O_HDR: begin
        if (free) begin
          emit = 1'b1;
          oidx_nxt = oidx_r + 4'h1;
          if (oidx_r < 4'h3) begin
            ebyte = hdr[8'(5'd23 - 5'(oidx_r) * 5'd8) -: 8];
          end else if (oidx_r < 4'h6) begin
            ebyte = msf_digit(hd_r.src, 2'(oidx_r - 4'h3));
          end else begin
            ebyte = msf_digit(hd_r.len, 2'(oidx_r - 4'h6));
          end
          if (oidx_r == 4'h8 || (oidx_r == 4'h5 && !hd_r.binary)) begin
            ost_nxt = left_r == 8'h00 ? O_CR : O_DATA;
          end
        end
      end
      O_DATA: begin
        if (byte_take) begin
          emit = !drop_r;
          ebyte = rx_byte;
          left_nxt = left_r - 8'h01;
          if (left_r == 8'h01) begin
            ost_nxt = (drop_r || ostream_r) ? O_IDLE : O_CR;
          end
        end
      end
      O_CR: begin
        if (free) begin
          emit = 1'b1;
          ebyte = CH_CR;
          ost_nxt = O_LF;
        end
      end
      O_LF: begin
        if (free) begin
          emit = 1'b1;
          ebyte = CH_LF;
          ost_nxt = O_IDLE;
        end
      end
      default: ost_nxt = O_IDLE;
    endcase
    hout_valid_nxt = emit || (hout_valid_r && !hout_ready);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ost_r <= O_IDLE;
      oidx_r <= 4'h0;
      left_r <= 8'h00;
      drop_r <= 1'b0;
      ostream_r <= 1'b0;
      rsp_code_r <= RESP_SEND_OK;
      hd_r <= '0;
      hout_valid_r <= 1'b0;
      hout_data_r <= 8'h00;
      rx_head_ready_r <= 1'b0;
      rx_byte_ready_r <= 1'b0;
    end else begin
      ost_r <= ost_nxt;
      oidx_r <= oidx_nxt;
      left_r <= left_nxt;
      drop_r <= drop_nxt;
      ostream_r <= ostream_nxt;
      if (take_acc) begin
        rsp_code_r <= acc_code_r;
      end else if (take_fin) begin
        rsp_code_r <= fin_code_r;
      end
      if (head_take) begin
        hd_r <= rx_head;
      end
      hout_valid_r <= hout_valid_nxt;
      if (emit) begin
        hout_data_r <= ebyte;
      end
      rx_head_ready_r <= ost_nxt == O_IDLE && !head_take;
      // One byte per cycle pair; the held output must be empty first unless the packet is dropped
      rx_byte_ready_r <= ost_nxt == O_DATA && left_nxt != 8'h00 && !byte_take
        && (drop_nxt || !hout_valid_nxt);
    end
  end

  // Acknowledge and duplicate tracking of received packets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_req_r <= 1'b0;
      seen_r <= 1'b0;
      last_src_r <= 8'h00;
      last_seq_r <= 1'b0;
    end else begin
      ack_req_r <= head_take && !rx_head.bcast;
      if (head_take && rx_head.bcast) begin
        seen_r <= 1'b1;
        last_src_r <= rx_head.src;
        last_seq_r <= rx_head.seq;
      end
    end
  end

  assign hin_ready = hin_ready_r;
  assign hout_valid = hout_valid_r;
  assign hout_data = hout_data_r;
  assign radio_byte_valid = radio_byte_valid_r;
  assign radio_byte = radio_byte_r;
  assign radio_req_valid = desc_valid_r;
  assign radio_req = desc_r;
  assign rx_head_ready = rx_head_ready_r;
  assign rx_byte_ready = rx_byte_ready_r;
  assign ack_req = ack_req_r;
  assign in_tx = in_tx_r;

endmodule

//--- test/msf_framer_props.sv
// Port assertions of the serial command framer
module msf_framer_props
  import msf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic cfg_stream_mode,
  input wire logic [7:0] cfg_dest,
  input wire logic hout_valid,
  input wire logic [7:0] hout_data,
  input wire logic hout_ready,
  input wire logic radio_byte_valid,
  input wire logic [7:0] radio_byte,
  input wire logic radio_byte_ready,
  input wire logic radio_req_valid,
  input wire msf_tx_desc_type radio_req,
  input wire logic radio_done,
  input wire logic rx_head_valid,
  input wire msf_rx_head_type rx_head,
  input wire logic rx_head_ready,
  input wire logic ack_req,
  input wire logic in_tx
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_addressed: assert property (
    rx_head_valid && rx_head_ready && !rx_head.bcast |=> ack_req) else $error("ack missing");
  a_no_bcast_ack: assert property (
    rx_head_valid && rx_head_ready && rx_head.bcast |=> !ack_req) else $error("bcast acked");
  a_hout_held: assert property (
    hout_valid && !hout_ready |=> hout_valid && $stable(hout_data)) else $error("hout dropped");
  a_byte_held: assert property (
    radio_byte_valid && !radio_byte_ready |=> radio_byte_valid && $stable(radio_byte))
    else $error("byte dropped");
  a_stream_dest: assert property (
    radio_req_valid && cfg_stream_mode |-> radio_req.dest == cfg_dest) else $error("bad dest");
  a_bcast_flag: assert property (
    radio_req_valid |-> radio_req.bcast == (radio_req.dest == BCAST_ADDR))
    else $error("bcast flag wrong");
  a_req_in_tx: assert property (
    radio_req_valid |=> in_tx) else $error("req outside tx");
  a_done_exit: assert property (
    radio_done && in_tx && !cfg_stream_mode |-> ##[1:3] !in_tx) else $error("stuck in tx");
endmodule

bind msf_framer msf_framer_props msf_framer_props_inst (.clk, .rst, .cfg_stream_mode,
  .cfg_dest, .hout_valid, .hout_data, .hout_ready, .radio_byte_valid, .radio_byte,
  .radio_byte_ready, .radio_req_valid, .radio_req, .radio_done, .rx_head_valid, .rx_head,
  .rx_head_ready, .ack_req, .in_tx);

//--- test/msf_host_model.sv
// Behavioural host terminal on the framer's byte lines
module msf_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host byte lines
  output logic hin_valid,
  output logic [7:0] hin_data,
  input wire logic hin_ready,
  input wire logic hout_valid,
  input wire logic [7:0] hout_data,
  output logic hout_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  bit slow = 0;
  initial begin
    hin_valid = 1'b0;
    hin_data = 8'h00;
    hout_ready = 1'b0;
  end
  // A slow host is only ready on every other cycle
  always @(posedge clk) begin
    if (hout_valid && hout_ready) rx_q.push_back(hout_data);
    #1 hout_ready = !rst && (!slow || !hout_ready);
  end
  // Caller keeps messages short and waits for responses between sends
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk) #1;
      hin_valid = 1'b1;
      hin_data = s[i];
      do @(posedge clk); while (hin_ready !== 1'b1);
      #1 hin_valid = 1'b0;
      hin_data = ~s[i];
    end
  endtask
endmodule

//--- test/msf_framer_bench.sv
// Self-checking bench of the serial command framer
module msf_framer_bench
  import msf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cfg_stream_mode, hin_valid, hin_ready, hout_valid, hout_ready, in_tx;
  logic radio_byte_valid, radio_byte_ready, radio_req_valid, radio_done, radio_ok, ack_req;
  logic rx_head_valid, rx_head_ready, rx_byte_valid, rx_byte_ready;
  logic [1:0] cfg_trigger;
  logic [7:0] cfg_term, cfg_count, cfg_timeout_ms, cfg_dest, hin_data, hout_data;
  logic [7:0] radio_byte, rx_byte;
  msf_tx_desc_type radio_req;
  msf_rx_head_type rx_head;
  msf_tx_desc_type req_q[$];
  int errors = 0;
  int n_checks = 0;
  msf_framer #(.TICKS_PER_MS(10)) msf_framer_inst (.clk, .rst, .cfg_stream_mode,
    .cfg_trigger, .cfg_term, .cfg_count, .cfg_timeout_ms, .cfg_dest, .hin_valid, .hin_data,
    .hin_ready, .hout_valid, .hout_data, .hout_ready, .radio_byte_valid, .radio_byte,
    .radio_byte_ready, .radio_req_valid, .radio_req, .radio_req_ready(1'b1), .radio_done,
    .radio_ok, .rx_head_valid, .rx_head, .rx_head_ready, .rx_byte_valid, .rx_byte,
    .rx_byte_ready, .ack_req, .in_tx);
  msf_host_model msf_host_model_inst (.clk, .rst, .hin_valid, .hin_data, .hin_ready,
    .hout_valid, .hout_data, .hout_ready);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (radio_req_valid) req_q.push_back(radio_req);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hexp(input string s);
    for (int t = 0; t < 3000 && msf_host_model_inst.rx_q.size() < s.len(); t++) @(posedge clk);
    for (int i = 0; i < s.len(); i++) chk(msf_host_model_inst.rx_q[i], s[i]);
    msf_host_model_inst.rx_q.delete();
  endtask
  task automatic pkt(input string s, input bit ok, input string r, input logic [7:0] d, n);
    msf_host_model_inst.send(s);
    hexp("P1\r\n");
    chk(in_tx, 1'b1);
    chk({req_q[0].dest, req_q[0].len}, {d, n});
    @(posedge clk) #1 {radio_done, radio_ok} = {1'b1, ok};
    @(posedge clk) #1 radio_done = 1'b0;
    hexp(r);
    chk(in_tx, 1'b0);
    req_q.delete();
  endtask
  task automatic rx(input logic [18:0] h, input string p);
    @(posedge clk) #1 {rx_head_valid, rx_head} = {1'b1, h};
    do @(posedge clk); while (rx_head_ready !== 1'b1);
    #1 {rx_head_valid, rx_head} = {1'b0, ~h};
    for (int i = 0; i < p.len(); i++) begin
      @(posedge clk) #1 {rx_byte_valid, rx_byte} = {1'b1, p[i]};
      do @(posedge clk); while (rx_byte_ready !== 1'b1);
      #1 {rx_byte_valid, rx_byte} = {1'b0, ~p[i]};
    end
  endtask
  task automatic t_packet;
    chk({in_tx, radio_req_valid, hout_valid}, 3'h0);
    pkt("@TXT012HI\r\n", 1'b1, "P0\r\n", 8'h0c, 8'h02);
    pkt("@TBN012003A\rC\r\n", 1'b0, "N2\r\n", 8'h0c, 8'h03);
    pkt("@TXT255A\r\n", 1'b0, "P0\r\n", 8'hff, 8'h01);
    msf_host_model_inst.send("@TXR001X\r\n");
    hexp("N1\r\n");
    msf_host_model_inst.send("@TXT256A\r\n");
    hexp("N1\r\n");
    chk(req_q.size(), 0);
    $display("packet test ended");
  endtask
  task automatic t_receive;
    msf_host_model_inst.slow = 1'b1;
    rx({8'h0f, 8'h05, 3'h4}, "HELLO");
    hexp("RBN015005HELLO\r\n");
    rx({8'h0f, 8'h02, 3'h0}, "HI");
    hexp("RXT015HI\r\n");
    rx({8'h0f, 8'h01, 3'h3}, "Z");
    rx({8'h0f, 8'h01, 3'h3}, "Z");
    hexp("RXT015Z\r\n");
    repeat (40) @(posedge clk);
    chk(msf_host_model_inst.rx_q.size(), 0);
    msf_host_model_inst.slow = 1'b0;
    $display("receive test ended");
  endtask
  task automatic t_stream;
    #1 cfg_stream_mode = 1'b1;
    msf_host_model_inst.send("HELLO\r\n");
    repeat (30) @(posedge clk);
    chk({req_q.size(), req_q[0].len}, {8'h01, 8'h07});
    chk(msf_host_model_inst.rx_q.size(), 0);
    #1 cfg_trigger = TRIG_COUNT;
    req_q.delete();
    msf_host_model_inst.send("ABCDEF");
    repeat (30) @(posedge clk);
    chk({req_q.size(), req_q[1].len}, {8'h02, 8'h03});
    #1 cfg_trigger = TRIG_TIMEOUT;
    req_q.delete();
    msf_host_model_inst.send("AB");
    repeat (60) @(posedge clk);
    chk({req_q.size(), req_q[0].len}, {8'h01, 8'h02});
    #1 cfg_trigger = TRIG_TERM;
    req_q.delete();
    radio_byte_ready = 1'b0;
    fork
      msf_host_model_inst.send("ABCDEFGHIJKLMNOPQ");
      repeat (200) @(posedge clk);
    join_any
    chk(hin_ready, 1'b0);
    #1 radio_byte_ready = 1'b1;
    wait fork;
    msf_host_model_inst.send("\n");
    repeat (60) @(posedge clk);
    chk(req_q[0].len, 8'h12);
    rx({8'h01, 8'h03, 3'h0}, "HI\n");
    hexp("HI\n");
    $display("stream test ended");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #6_000_000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    {rst, cfg_stream_mode, radio_done, radio_ok, rx_head_valid, rx_byte_valid} = 6'h20;
    {cfg_trigger, cfg_term, cfg_count, cfg_timeout_ms} = {TRIG_TERM, CH_LF, 8'h03, 8'h02};
    {cfg_dest, radio_byte_ready, rx_head, rx_byte} = {8'h07, 1'b1, 19'h0, 8'h00};
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    t_packet();
    t_receive();
    t_stream();
    end_sim();
  end
endmodule
